// ===== design/occk_pkg.sv
package occk_pkg;

    // timing base
    localparam longint OCCK_SYS_HZ = 25_000_000;
    localparam longint OCCK_LO_BASE_HZ = 500_000;
    localparam longint OCCK_HI_BASE_HZ = 16_000_000;
    localparam int OCCK_NCO_BITS = 16;
    // phase increments per sys_clk cycle for the two internal base rates
    localparam logic [15:0] OCCK_LO_INC = 16'((OCCK_LO_BASE_HZ << OCCK_NCO_BITS) / OCCK_SYS_HZ);
    localparam logic [15:0] OCCK_HI_INC = 16'((OCCK_HI_BASE_HZ << OCCK_NCO_BITS) / OCCK_SYS_HZ);

    // start-up counter: 1024 oscillator input cycles
    localparam int OCCK_STARTUP_CYCLES = 1024;
    localparam logic [10:0] OCCK_STARTUP_LAST = 11'(OCCK_STARTUP_CYCLES - 1);

    // clock-source-select codes of the first configuration word
    localparam logic [2:0] OCCK_SRC_RC_CLK = 3'h7;
    localparam logic [2:0] OCCK_SRC_RC_IO = 3'h6;
    localparam logic [2:0] OCCK_SRC_INT_CLK = 3'h5;
    localparam logic [2:0] OCCK_SRC_INT_IO = 3'h4;
    localparam logic [2:0] OCCK_SRC_EXT = 3'h3;
    localparam logic [2:0] OCCK_SRC_HI_GAIN = 3'h2;
    localparam logic [2:0] OCCK_SRC_MID_GAIN = 3'h1;
    localparam logic [2:0] OCCK_SRC_LO_POWER = 3'h0;

    // register byte offsets
    localparam logic [3:0] OCCK_OFS_CTRL = 4'h0;
    localparam logic [3:0] OCCK_OFS_TRIM = 4'h4;
    localparam logic [3:0] OCCK_OFS_CFG = 4'h8;

    // control register fields
    localparam int OCCK_CTRL_SEL_LSB = 4;
    localparam int OCCK_CTRL_LOCKED_BIT = 3;
    localparam int OCCK_CTRL_STABLE_BIT = 2;
    localparam logic [1:0] OCCK_FREQ_SEL_RST = 2'h2;
    localparam logic [5:0] OCCK_TRIM_RST = 6'h00;

    typedef enum logic [2:0] {
        OCCK_LO_POWER, OCCK_MID_GAIN, OCCK_HI_GAIN, OCCK_EXT, OCCK_INT_IO, OCCK_INT_CLK,
        OCCK_RC_IO, OCCK_RC_CLK
    } occk_mode_t;

    typedef enum logic [1:0] {
        OCCK_SU_CAPTURE, OCCK_SU_COUNT, OCCK_SU_RUN, OCCK_SU_SLEEP
    } occk_su_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } occk_av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } occk_av_rsp_t;

    typedef struct packed {
        logic cfg_taken;
        occk_mode_t mode;
        logic high_range;
        occk_su_t su;
        logic [10:0] su_cnt;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic [1:0] freq_sel;
        logic [1:0] act_sel;
        logic [2:0] ps_cnt;
        logic [15:0] nco_acc;
        logic [15:0] nco_inc;
        logic [11:0] slew_cnt;
        logic [5:0] trim;
        logic [11:0] age;
        logic locked;
        logic stable;
        logic [1:0] div4;
        logic fosc_tick;
        logic core_run;
        logic out_o;
        logic out_oe;
        logic in_free;
        logic out_free;
        logic [1:0] gain;
        logic waitreq;
        logic [31:0] rdata;
    } occk_state_t;

    localparam occk_state_t OCCK_STATE_RST = '{
        mode: OCCK_LO_POWER, su: OCCK_SU_CAPTURE, freq_sel: OCCK_FREQ_SEL_RST,
        act_sel: OCCK_FREQ_SEL_RST, trim: OCCK_TRIM_RST, waitreq: 1'b1, default: '0
    };

endpackage

// ===== design/occk_top.sv
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - eight clock source modes, picked by the configuration word, not software.
// - external RC mode drives the output pin with system clock divided by four.
// - RC pins-free mode takes RC on input pin, frees output pin for I/O.
// - internal with clock output frees input pin, drives output pin at frequency/4.
// - internal without clock output frees both oscillator pins.
// - external clock mode takes the input pin clock and frees the output pin.
// - internal base is 500 kHz, or 16 MHz when high range is configured.
// - high range is fixed at configuration; software picks among four frequencies.
// - two-bit select divides by 1, 2, 4 or 8 for codes 11 to 00.
// - every reset loads the frequency select with 10.
// - a new frequency applies without restarting the running source.
// - locked status bit 3 reads 1 once within 2 percent, else 0.
// - control register bits 7-6 and 1-0 read zero.
// - six-bit two's complement trim, writable, resets to zero.
// - trim change slews frequency gradually; stable bit 2 reads 0 until the slew completes.
// - trim register bits 7-6 read zero.
// - source codes 111 RC out, 110 RC io, 101/100 internal, 011 ext, 010-000 crystal.
// - crystal modes wait 1024 input cycles before release from reset or sleep.
// - external clock mode releases at once, no start-up count.
module occk_top #(
    parameter logic [11:0] LOCK_TICKS = 12'h040,
    parameter logic [11:0] STABLE_TICKS = 12'h100,
    parameter logic [15:0] TRIM_STEP = 16'h0010,
    parameter logic [11:0] SLEW_CYCLES = 12'h010
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // programmed configuration word, caught after reset release
    input wire logic [2:0] cfg_clk_source,
    input wire logic cfg_high_range,
    // power state from the core
    input wire logic sleep_req,
    // oscillator pins
    input wire logic osc_input_pin,
    output logic osc_output_pin_o,
    output logic osc_output_pin_oe,
    output logic osc_input_pin_free,
    output logic osc_output_pin_free,
    output logic [1:0] crystal_gain,
    // system clock enable and release
    output logic fosc_tick,
    output logic core_run,
    // register bus
    input wire occk_pkg::occk_av_req_t av_req,
    output occk_pkg::occk_av_rsp_t av_rsp
);
    import occk_pkg::*;

    occk_state_t s_q;
    occk_state_t s_d;
    logic pin_rise;
    logic base_tick;
    logic int_tick;
    logic src_tick;
    logic xtal;
    logic [16:0] nco_sum;
    logic [15:0] nominal;
    logic [15:0] target;
    logic [15:0] trim_ext;
    logic [2:0] ps_mask;
    logic [7:0] ctrl_rd;
    logic [7:0] trim_rd;
    logic [7:0] cfg_rd;
    logic [31:0] rd_mux;

    function automatic occk_mode_t decode_mode(input logic [2:0] code);
        occk_mode_t m;
        unique case (code)
            OCCK_SRC_RC_CLK: m = OCCK_RC_CLK;
            OCCK_SRC_RC_IO: m = OCCK_RC_IO;
            OCCK_SRC_INT_CLK: m = OCCK_INT_CLK;
            OCCK_SRC_INT_IO: m = OCCK_INT_IO;
            OCCK_SRC_EXT: m = OCCK_EXT;
            OCCK_SRC_HI_GAIN: m = OCCK_HI_GAIN;
            OCCK_SRC_MID_GAIN: m = OCCK_MID_GAIN;
            OCCK_SRC_LO_POWER: m = OCCK_LO_POWER;
        endcase
        return m;
    endfunction

    function automatic logic is_crystal(input occk_mode_t m);
        return (m == OCCK_LO_POWER) || (m == OCCK_MID_GAIN) || (m == OCCK_HI_GAIN);
    endfunction

    function automatic logic is_internal(input occk_mode_t m);
        return (m == OCCK_INT_IO) || (m == OCCK_INT_CLK);
    endfunction

    always_comb begin
        s_d = s_q;
        // pin synchroniser; only the second and third stages feed logic
        s_d.pin_s1 = osc_input_pin;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.pin_s3 = s_q.pin_s2;
        pin_rise = s_q.pin_s2 & ~s_q.pin_s3;
        xtal = is_crystal(s_q.mode);

        // internal source model: a phase accumulator stands in for the analog oscillator
        nominal = cfg_high_range ? OCCK_HI_INC : OCCK_LO_INC;
        if (s_q.cfg_taken) begin
            nominal = s_q.high_range ? OCCK_HI_INC : OCCK_LO_INC;
        end
        trim_ext = {{10{s_q.trim[5]}}, s_q.trim};
        target = nominal + 16'(trim_ext * TRIM_STEP);
        nco_sum = {1'b0, s_q.nco_acc} + {1'b0, s_q.nco_inc};
        base_tick = s_q.cfg_taken & nco_sum[16];
        s_d.nco_acc = nco_sum[15:0];

        // slew the increment one step at a time so the frequency drifts, not jumps
        if (s_q.cfg_taken) begin
            if (s_q.slew_cnt == SLEW_CYCLES - 12'h001) begin
                s_d.slew_cnt = '0;
                if (s_q.nco_inc < target) begin
                    s_d.nco_inc = s_q.nco_inc + 16'h0001;
                end else if (s_q.nco_inc > target) begin
                    s_d.nco_inc = s_q.nco_inc - 16'h0001;
                end
            end else begin
                s_d.slew_cnt = s_q.slew_cnt + 12'h001;
            end
        end

        // lock and accuracy status follow the age of the running source
        if (base_tick && s_q.age != STABLE_TICKS) begin
            s_d.age = s_q.age + 12'h001;
        end
        s_d.locked = s_q.age >= LOCK_TICKS;
        s_d.stable = (s_q.age >= STABLE_TICKS) && (s_q.nco_inc == target);

        // postscaler; the ratio only changes when all ratios share an edge
        unique case (s_q.act_sel)
            2'h3: ps_mask = 3'h0;
            2'h2: ps_mask = 3'h1;
            2'h1: ps_mask = 3'h3;
            2'h0: ps_mask = 3'h7;
        endcase
        int_tick = base_tick && ((s_q.ps_cnt & ps_mask) == ps_mask);
        if (base_tick) begin
            s_d.ps_cnt = s_q.ps_cnt + 3'h1;
            if (s_q.ps_cnt == 3'h7) begin
                s_d.act_sel = s_q.freq_sel;
            end
        end

        // system clock: internal postscaler output or the external pin edges
        src_tick = is_internal(s_q.mode) ? int_tick : (s_q.cfg_taken & pin_rise);
        if (src_tick) begin
            s_d.div4 = s_q.div4 + 2'h1;
        end

        // start-up sequencing
        unique case (s_q.su)
            OCCK_SU_CAPTURE: begin
                s_d.cfg_taken = 1'b1;
                s_d.mode = decode_mode(cfg_clk_source);
                s_d.high_range = cfg_high_range;
                s_d.nco_inc = nominal;
                s_d.su_cnt = '0;
                s_d.su = is_crystal(decode_mode(cfg_clk_source)) ?
                    OCCK_SU_COUNT : OCCK_SU_RUN;
            end
            OCCK_SU_COUNT: begin
                if (pin_rise) begin
                    if (s_q.su_cnt == OCCK_STARTUP_LAST) begin
                        s_d.su = OCCK_SU_RUN;
                    end else begin
                        s_d.su_cnt = s_q.su_cnt + 11'h001;
                    end
                end
            end
            OCCK_SU_RUN: begin
                if (sleep_req) begin
                    s_d.su = OCCK_SU_SLEEP;
                end
            end
            OCCK_SU_SLEEP: begin
                if (!sleep_req) begin
                    s_d.su_cnt = '0;
                    s_d.su = xtal ? OCCK_SU_COUNT : OCCK_SU_RUN;
                end
            end
        endcase
        s_d.core_run = (s_d.su == OCCK_SU_RUN);
        s_d.fosc_tick = src_tick & (s_q.su == OCCK_SU_RUN);

        // pin roles per mode
        s_d.out_o = 1'b0;
        s_d.out_oe = 1'b0;
        s_d.in_free = 1'b0;
        s_d.out_free = 1'b0;
        s_d.gain = 2'h0;
        if (s_q.cfg_taken) begin
            unique case (s_q.mode)
                OCCK_RC_CLK: begin
                    s_d.out_oe = 1'b1;
                    s_d.out_o = s_q.div4[1];
                end
                OCCK_RC_IO: s_d.out_free = 1'b1;
                OCCK_INT_CLK: begin
                    s_d.in_free = 1'b1;
                    s_d.out_oe = 1'b1;
                    s_d.out_o = s_q.div4[1];
                end
                OCCK_INT_IO: begin
                    s_d.in_free = 1'b1;
                    s_d.out_free = 1'b1;
                end
                OCCK_EXT: s_d.out_free = 1'b1;
                OCCK_HI_GAIN: s_d.gain = 2'h2;
                OCCK_MID_GAIN: s_d.gain = 2'h1;
                OCCK_LO_POWER: s_d.gain = 2'h0;
            endcase
        end

        // register bus: one wait cycle, then waitrequest low for exactly one cycle
        ctrl_rd = {2'h0, s_q.freq_sel, s_q.locked, s_q.stable, 2'h0};
        trim_rd = {2'h0, s_q.trim};
        cfg_rd = {3'h0, s_q.core_run, s_q.high_range, 3'(s_q.mode)};
        unique case (av_req.address)
            OCCK_OFS_CTRL: rd_mux = {24'h00_0000, ctrl_rd};
            OCCK_OFS_TRIM: rd_mux = {24'h00_0000, trim_rd};
            OCCK_OFS_CFG: rd_mux = {24'h00_0000, cfg_rd};
            default: rd_mux = 32'h0000_0000;
        endcase
        if (s_q.waitreq) begin
            if (av_req.read || av_req.write) begin
                s_d.waitreq = 1'b0;
                s_d.rdata = av_req.read ? rd_mux : 32'h0000_0000;
            end
        end else begin
            s_d.waitreq = 1'b1;
            s_d.rdata = 32'h0000_0000;
            // the write lands on the edge where the master sees waitrequest low
            if (av_req.write && av_req.byteenable[0]) begin
                if (av_req.address == OCCK_OFS_CTRL) begin
                    s_d.freq_sel = av_req.writedata[OCCK_CTRL_SEL_LSB +: 2];
                end
                if (av_req.address == OCCK_OFS_TRIM) begin
                    s_d.trim = av_req.writedata[5:0];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= OCCK_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign osc_output_pin_o = s_q.out_o;
    assign osc_output_pin_oe = s_q.out_oe;
    assign osc_input_pin_free = s_q.in_free;
    assign osc_output_pin_free = s_q.out_free;
    assign crystal_gain = s_q.gain;
    assign fosc_tick = s_q.fosc_tick;
    assign core_run = s_q.core_run;
    assign av_rsp.readdata = s_q.rdata;
    assign av_rsp.waitrequest = s_q.waitreq;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_captured;
        $rose(s_q.cfg_taken);
    endsequence

    sequence s_read_answer(logic [3:0] ofs);
        av_req.read && av_req.address == ofs && s_q.waitreq ##1 !s_q.waitreq;
    endsequence

    property p_mode_fixed;
        s_q.cfg_taken |=> $stable(s_q.mode) && $stable(s_q.high_range);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed after capture");

    property p_rc_clkout;
        s_q.cfg_taken && s_q.mode == OCCK_RC_CLK |=> osc_output_pin_oe && !osc_output_pin_free;
    endproperty
    a_rc_clkout: assert property (p_rc_clkout) else $error("rc mode not driving clkout");

    property p_pins_free;
        s_q.cfg_taken |=> osc_output_pin_free ==
            $past(s_q.mode inside {OCCK_RC_IO, OCCK_INT_IO, OCCK_EXT});
    endproperty
    a_pins_free: assert property (p_pins_free) else $error("output pin role wrong");

    property p_int_input_free;
        s_q.cfg_taken |=> osc_input_pin_free == $past(is_internal(s_q.mode));
    endproperty
    a_int_input_free: assert property (p_int_input_free) else $error("input pin role wrong");

    property p_div4_step;
        src_tick |=> s_q.div4 == $past(s_q.div4) + 2'h1;
    endproperty
    a_div4_step: assert property (p_div4_step) else $error("clkout divider missed tick");

    property p_div1_every_base;
        s_q.act_sel == 2'h3 && base_tick |-> int_tick;
    endproperty
    a_div1_every_base: assert property (p_div1_every_base) else $error("divide by 1 slipped");

    property p_div8_spacing;
        s_q.act_sel == 2'h0 && int_tick |-> s_q.ps_cnt == 3'h7;
    endproperty
    a_div8_spacing: assert property (p_div8_spacing) else $error("divide by 8 off phase");

    property p_reset_sel;
        s_captured |-> s_q.freq_sel == OCCK_FREQ_SEL_RST && s_q.trim == OCCK_TRIM_RST;
    endproperty
    a_reset_sel: assert property (p_reset_sel) else $error("reset values wrong");

    property p_switch_aligned;
        s_q.act_sel != $past(s_q.act_sel) |-> $past(base_tick) && $past(s_q.ps_cnt) == 3'h7;
    endproperty
    a_switch_aligned: assert property (p_switch_aligned) else $error("ratio switched mid-cycle");

    property p_ctrl_read;
        s_read_answer(OCCK_OFS_CTRL) |-> av_rsp.readdata[7:6] == 2'h0 &&
            av_rsp.readdata[1:0] == 2'h0 &&
            av_rsp.readdata[OCCK_CTRL_LOCKED_BIT] == $past(s_q.locked);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    property p_stable_needs_age;
        s_q.stable |-> $past(s_q.age) >= STABLE_TICKS && s_q.locked;
    endproperty
    a_stable_needs_age: assert property (p_stable_needs_age) else $error("stable too early");

    property p_trim_read;
        s_read_answer(OCCK_OFS_TRIM) |-> av_rsp.readdata[7:6] == 2'h0;
    endproperty
    a_trim_read: assert property (p_trim_read) else $error("trim upper bits set");

    property p_slew_gradual;
        s_q.cfg_taken && $past(s_q.cfg_taken) |->
            (s_q.nco_inc - $past(s_q.nco_inc) + 16'h0001) <= 16'h0002;
    endproperty
    a_slew_gradual: assert property (p_slew_gradual) else $error("tuning jumped");

    property p_xtal_release;
        $rose(core_run) && xtal |-> $past(s_q.su_cnt) == OCCK_STARTUP_LAST;
    endproperty
    a_xtal_release: assert property (p_xtal_release) else $error("crystal released early");

    property p_ext_immediate;
        s_captured ##0 s_q.mode == OCCK_EXT |=> core_run;
    endproperty
    a_ext_immediate: assert property (p_ext_immediate) else $error("ext clock delayed");

    property p_bus_one_cycle;
        !av_rsp.waitrequest |=> av_rsp.waitrequest;
    endproperty
    a_bus_one_cycle: assert property (p_bus_one_cycle) else $error("waitrequest low too long");

endmodule

// ===== dv/occk_osc_model.sv
`timescale 1ns/1ps
module occk_osc_model #(
    parameter int HALF_NS = 120
) (
    // source control
    input wire logic run,
    // oscillator input pin
    output logic osc_out
);
    // stands still low while stopped, so no stale edge reaches the start-up count
    initial begin
        osc_out = 1'b0;
        forever begin
            #(HALF_NS);
            osc_out = run ? ~osc_out : 1'b0;
        end
    end
endmodule

// ===== dv/occk_top_tb.sv
`timescale 1ns/1ps
module occk_top_tb;
    import occk_pkg::*;
    logic sys_clk, rst_n, cfg_high_range, sleep_req, osc_run, osc_in;
    logic [2:0] cfg_clk_source;
    logic out_o, out_oe, in_free, out_free, fosc_tick, core_run;
    logic [1:0] crystal_gain;
    occk_av_req_t av_req;
    occk_av_rsp_t av_rsp;
    logic [31:0] rd;
    int fail_count, compares, edge_cnt, ticks, outs;
    // {code, in_free, out_free, oe, gain, run}, one row per mode, osc stopped
    logic [8:0] rows [8] = '{9'h000, 9'h042, 9'h084, 9'h0D1, 9'h131, 9'h169, 9'h191, 9'h1C9};

    occk_top i_occk_top (
        .sys_clk(sys_clk), .rst_n(rst_n), .cfg_clk_source(cfg_clk_source),
        .cfg_high_range(cfg_high_range), .sleep_req(sleep_req), .osc_input_pin(osc_in),
        .osc_output_pin_o(out_o), .osc_output_pin_oe(out_oe), .osc_input_pin_free(in_free),
        .osc_output_pin_free(out_free), .crystal_gain(crystal_gain), .fosc_tick(fosc_tick),
        .core_run(core_run), .av_req(av_req), .av_rsp(av_rsp)
    );
    occk_osc_model i_occk_osc_model (.run(osc_run), .osc_out(osc_in));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge osc_in) edge_cnt++;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic near(input int got, input int exp);
        check(32'(got >= exp - 1 && got <= exp + 1), 32'h0000_0001);
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
    endtask

    // one Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] wd,
                       input logic [3:0] be);
        av_req <= '{read: ~wr, write: wr, address: a, byteenable: be,
                    writedata: {24'h00_0000, wd}};
        @(posedge sys_clk);
        // no local limit: a slave that never answers is caught by the watchdog
        while (av_rsp.waitrequest !== 1'b0) begin
            @(posedge sys_clk);
        end
        rd = av_rsp.readdata;
        av_req <= '0;
        @(posedge sys_clk);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00, 4'hF);
        check(rd, exp);
    endtask

    task automatic win(input int cyc);
        logic prev;
        ticks = 0;
        outs = 0;
        prev = out_o;
        repeat (cyc) begin
            @(posedge sys_clk);
            ticks += int'(fosc_tick === 1'b1);
            outs += int'(out_o === 1'b1 && prev === 1'b0);
            prev = out_o;
        end
    endtask

    task automatic wait_run;
        int n;
        n = 0;
        while (core_run !== 1'b1 && n < 9000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 9000) fail_count++;
    endtask

    task tally_and_finish;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #2_400_000;
        fail_count++;
        tally_and_finish;
    end

    initial begin
        sleep_req = 1'b0;
        osc_run = 1'b0;
        av_req = '0;
        fail_count = 0;
        compares = 0;
        edge_cnt = 0;
        // pin roles and reset values for every mode, odd codes in high range
        for (int i = 7; i >= 0; i--) begin
            cfg_clk_source <= rows[i][8:6];
            cfg_high_range <= i[0];
            do_reset;
            repeat (4) @(posedge sys_clk);
            check({in_free, out_free, out_oe, crystal_gain, core_run}, rows[i][5:0]);
            rdchk(OCCK_OFS_CFG, 32'({rows[i][0], i[0], rows[i][8:6]}));
            rdchk(OCCK_OFS_CTRL, 32'h0000_0020);
            rdchk(OCCK_OFS_TRIM, 32'h0000_0000);
        end
        // crystal start-up count after reset and after sleep
        cfg_clk_source <= OCCK_SRC_LO_POWER;
        do_reset;
        edge_cnt = 0;
        osc_run <= 1'b1;
        repeat (100) @(posedge sys_clk);
        check(core_run, 1'b0);
        wait_run;
        near(edge_cnt, 1024);
        sleep_req <= 1'b1;
        repeat (10) @(posedge sys_clk);
        win(50);
        check({core_run, 31'(ticks)}, 32'h0000_0000);
        edge_cnt = 0;
        sleep_req <= 1'b0;
        wait_run;
        near(edge_cnt, 1024);
        // external clock: one tick per input cycle, immediate wake
        cfg_clk_source <= OCCK_SRC_EXT;
        do_reset;
        repeat (20) @(posedge sys_clk);
        win(240);
        near(ticks, 40);
        sleep_req <= 1'b1;
        repeat (5) @(posedge sys_clk);
        check(core_run, 1'b0);
        sleep_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check(core_run, 1'b1);
        // rc with clock out: output at a quarter of the source
        cfg_clk_source <= OCCK_SRC_RC_CLK;
        do_reset;
        repeat (40) @(posedge sys_clk);
        win(240);
        near(outs, 10);
        osc_run <= 1'b0;
        // internal high range: reset divide, then every divide code
        cfg_clk_source <= OCCK_SRC_INT_CLK;
        cfg_high_range <= 1'b1;
        do_reset;
        repeat (40) @(posedge sys_clk);
        win(2500);
        near(ticks, 800);
        for (int c = 3; c >= 0; c--) begin
            bus(1'b1, OCCK_OFS_CTRL, 8'(c << 4), 4'hF);
            repeat (40) @(posedge sys_clk);
            win(2500);
            near(ticks, 1600 >> (3 - c));
            near(outs, 400 >> (3 - c));
        end
        rdchk(OCCK_OFS_CTRL, 32'h0000_000C);
        bus(1'b1, OCCK_OFS_CTRL, 8'hFF, 4'hF);
        rdchk(OCCK_OFS_CTRL, 32'h0000_003C);
        bus(1'b1, OCCK_OFS_TRIM, 8'hFF, 4'hF);
        rdchk(OCCK_OFS_TRIM, 32'h0000_003F);
        bus(1'b0, OCCK_OFS_CTRL, 8'h00, 4'hF);
        check(rd[2], 1'b0);
        bus(1'b1, OCCK_OFS_TRIM, 8'h05, 4'h0);
        rdchk(OCCK_OFS_TRIM, 32'h0000_003F);
        bus(1'b1, 4'hC, 8'hAA, 4'hF);
        rdchk(4'hC, 32'h0000_0000);
        do_reset;
        rdchk(OCCK_OFS_CTRL, 32'h0000_0020);
        rdchk(OCCK_OFS_TRIM, 32'h0000_0000);
        // internal low range at the reset divide
        cfg_clk_source <= OCCK_SRC_INT_IO;
        cfg_high_range <= 1'b0;
        do_reset;
        repeat (40) @(posedge sys_clk);
        win(2500);
        near(ticks, 25);
        tally_and_finish;
    end
endmodule
